// >>> design/pspx_slave_port.sv
// Chosen here: the APB slave port.
`timescale 1ns/10ps
// What this block does
// RULE1: each control pin is input when its direction bit is 1, output when 0
// RULE2: a control pin set as analog input reads back as zero
// RULE3: direction bits drive control pins even while they are analog inputs
// RULE4: after reset the control pins are analog inputs
// RULE5: slave-port select 1 makes control pins read, write and chip-select strobes
// RULE6: software sets control pins as digital inputs before slave-port use
// RULE7: in slave-port use the data-pin direction register is ignored
// RULE8: two data latches at one address: firmware writes out, firmware reads in
// RULE9: host writes with select and write low; firmware then reads live pins
// RULE10: select or write rising captures the data pins into the input latch
// RULE11: after a host write, set input-full and irq flag on phase four after two
// RULE12: firmware read of the data port clears input-full
// RULE13: host write while input-full sets overrun and still overwrites the latch
// RULE14: overrun clears only by data read then explicit zero write
// RULE15: select and read low drives output latch to pins, clears output-full
// RULE16: firmware write during host read reaches pins, output-full stays clear
// RULE17: read end stops driving pins, irq flag set on phase four after two
// RULE18: output-full stays low until firmware writes the output latch
// RULE19: outside slave-port use both full flags held clear, overrun kept
// RULE20: irq flag cleared by firmware only; enable bit masks the interrupt
// RULE21: strobes pass a two-stage synchroniser before edge detection
module pspx_slave_port
(
   // clock and reset
   input  wire logic                         clk_sys,
   input  wire logic                         reset,
   // apb slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [pspx_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [pspx_pkg::DATA_W-1:0]  pwdata,
   output logic      [pspx_pkg::DATA_W-1:0]  prdata,
   output logic                              pready,
   output logic                              pslverr,
   // data port pins
   input  wire logic [pspx_pkg::PORT_W-1:0]  dataPinIn,
   output logic      [pspx_pkg::PORT_W-1:0]  dataPinOut,
   output logic      [pspx_pkg::PORT_W-1:0]  dataPinOe,
   // control pins: read, write, chip select
   input  wire logic [pspx_pkg::CTRL_W-1:0]  ctrlPinIn,
   output logic      [pspx_pkg::CTRL_W-1:0]  ctrlPinOut,
   output logic      [pspx_pkg::CTRL_W-1:0]  ctrlPinOe,
   // interrupt request
   output logic                              slavePortIrq
);
   import pspx_pkg::*;

   // ==========================================================
   // state
   pspx_state_t r;
   pspx_state_t n;

   logic       apbAccess;
   logic       apbDone;
   logic [7:0] regIdx;
   logic       regHit;
   logic       ctrlDigital;
   logic       writeAct;
   logic       readAct;
   logic       writeEnd;
   logic       readEnd;
   logic       dataRead;
   logic       dataWrite;
   logic [7:0] readByte;

   localparam pspx_state_t RESET_ST = '{
      phase:        2'h0,
      ctrlSync1:    3'h7,
      ctrlSync2:    3'h7,
      dataSync1:    RST_LATCH,
      dataSync2:    RST_LATCH,
      writeActPrev: 1'h0,
      readActPrev:  1'h0,
      liveData:     RST_LATCH,
      inLatch:      RST_LATCH,
      outLatch:     RST_LATCH,
      ctrlLatch:    3'h0,
      dataDir:      RST_DATA_DIR,
      ctrlDir:      RST_CTRL_DIR,
      slave_port_select:      RST_PSP_MODE,
      in_buffer_full:          1'h0,
      out_buffer_full:          1'h0,
      in_buffer_overrun:         1'h0,
      ibovArm:      1'h0,
      irqFlags:     RST_IRQ_FLAGS,
      irqEn:        RST_IRQ_EN,
      anaCfg:       RST_ANALOG,
      wrStage:      STG_IDLE,
      rdStage:      STG_IDLE,
      prdata:       32'h0000_0000,
      pready:       1'h0,
      pslverr:      1'h0,
      dataOut:      RST_LATCH,
      dataOe:       8'h00,
      ctrlOut:      3'h0,
      ctrlOe:       3'h0,
      irq:          1'h0
   };

   // ==========================================================
   // completion wait: next second phase, then the fourth phase
   function automatic pspx_stage_t stepStage(pspx_stage_t s, logic start, logic [1:0] ph);
      pspx_stage_t t;
      t = s;
      case (s)
         STG_IDLE:    t = start ? STG_WAIT_Q2 : STG_IDLE;
         STG_WAIT_Q2: t = (ph == PH_SECOND) ? STG_WAIT_Q4 : STG_WAIT_Q2;
         STG_WAIT_Q4:
         begin
            if (ph == PH_FOURTH)
            begin
               t = start ? STG_WAIT_Q2 : STG_IDLE;
            end
         end
         default:     t = STG_IDLE;
      endcase
      return t;
   endfunction

   // ==========================================================
   // decode and strobe detection
   assign apbAccess   = psel & penable & ~r.pready;
   assign apbDone     = psel & penable & r.pready;
   assign regIdx      = paddr[9:2];
   assign ctrlDigital = (r.anaCfg == ANALOG_DIGITAL_CODE);
   assign writeAct    = r.slave_port_select & ~r.ctrlSync2[PIN_CS] & ~r.ctrlSync2[PIN_WRITE]; // see RULE21
   assign readAct     = r.slave_port_select & ~r.ctrlSync2[PIN_CS] & ~r.ctrlSync2[PIN_READ];  // see RULE21
   assign writeEnd    = r.writeActPrev & ~writeAct; // see RULE10
   assign readEnd     = r.readActPrev & ~readAct;
   assign dataRead    = apbDone & ~pwrite & regHit & (regIdx == IDX_DATA_PORT);
   assign dataWrite   = apbDone & pwrite & regHit & (regIdx == IDX_DATA_PORT);

   always_comb
   begin
      regHit = (paddr[1:0] == 2'h0);
      case (regIdx)
         IDX_DATA_PORT, IDX_CTRL_PORT, IDX_IRQ_FLAGS, IDX_DATA_DIR,
         IDX_CTRL_DIR, IDX_IRQ_EN, IDX_ANALOG: regHit = regHit;
         default:                              regHit = 1'b0;
      endcase
   end

   // ==========================================================
   // read mux
   always_comb
   begin
      readByte = 8'h00;
      case (regIdx)
         IDX_DATA_PORT: readByte = (r.slave_port_select & ~writeAct) ? r.inLatch : r.dataSync2; // see RULE8 RULE9
         IDX_CTRL_PORT: readByte = {5'h00, ctrlDigital ? r.ctrlSync2 : 3'h0};         // see RULE2
         IDX_IRQ_FLAGS: readByte = r.irqFlags;
         IDX_DATA_DIR:  readByte = r.dataDir;
         IDX_CTRL_DIR:  readByte = {r.in_buffer_full, r.out_buffer_full, r.in_buffer_overrun, r.slave_port_select, 1'b0, r.ctrlDir};
         IDX_IRQ_EN:    readByte = r.irqEn;
         IDX_ANALOG:    readByte = {5'h00, r.anaCfg};
         default:       readByte = 8'h00;
      endcase
   end

   // ==========================================================
   // next state
   always_comb
   begin
      n = r;
      n.phase     = r.phase + 2'h1;
      n.ctrlSync1 = ctrlPinIn;
      n.ctrlSync2 = r.ctrlSync1; // see RULE21
      n.dataSync1 = dataPinIn;
      n.dataSync2 = r.dataSync1;
      n.writeActPrev = writeAct;
      n.readActPrev  = readAct;

      // apb answer, one wait cycle
      n.pready  = apbAccess;
      n.pslverr = apbAccess & ~regHit;
      if (apbAccess)
      begin
         n.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, readByte};
      end

      // firmware writes
      if (apbDone & pwrite & regHit)
      begin
         case (regIdx)
            IDX_DATA_PORT:
            begin
               n.outLatch = pwdata[7:0]; // see RULE8
               n.out_buffer_full      = ~readAct;    // see RULE16 RULE18
            end
            IDX_CTRL_PORT: n.ctrlLatch = pwdata[2:0];
            IDX_IRQ_FLAGS: n.irqFlags  = pwdata[7:0]; // see RULE20
            IDX_DATA_DIR:  n.dataDir   = pwdata[7:0];
            IDX_CTRL_DIR:
            begin
               n.ctrlDir = pwdata[2:0];           // see RULE1
               n.slave_port_select = pwdata[BIT_PSP_MODE];  // see RULE5
               if (!pwdata[BIT_IN_BUFFER_OVERRUN] && r.ibovArm)
               begin
                  n.in_buffer_overrun    = 1'b0; // see RULE14
                  n.ibovArm = 1'b0;
               end
            end
            IDX_IRQ_EN:    n.irqEn  = pwdata[7:0];
            IDX_ANALOG:    n.anaCfg = pwdata[2:0];
            default:       n.irqEn  = r.irqEn;
         endcase
      end

      // firmware read of the data port
      if (dataRead)
      begin
         n.in_buffer_full = 1'b0; // see RULE12
         if (r.in_buffer_overrun)
         begin
            n.ibovArm = 1'b1; // see RULE14
         end
      end

      // host write capture
      if (writeAct)
      begin
         n.liveData = r.dataSync2;
      end
      if (writeEnd)
      begin
         n.inLatch = r.liveData; // see RULE10 RULE13
         if (r.in_buffer_full || r.wrStage != STG_IDLE)
         begin
            n.in_buffer_overrun = 1'b1; // see RULE13
         end
      end

      // completion flags, set wins over firmware clear
      n.wrStage = stepStage(r.wrStage, writeEnd, r.phase);
      n.rdStage = stepStage(r.rdStage, readEnd, r.phase);
      if (r.wrStage == STG_WAIT_Q4 && r.phase == PH_FOURTH)
      begin
         n.in_buffer_full = 1'b1;                    // see RULE11
         n.irqFlags[BIT_SLAVE_IRQ] = 1'b1; // see RULE11
      end
      if (r.rdStage == STG_WAIT_Q4 && r.phase == PH_FOURTH)
      begin
         n.irqFlags[BIT_SLAVE_IRQ] = 1'b1; // see RULE17
      end

      if (readAct)
      begin
         n.out_buffer_full = 1'b0; // see RULE15
      end
      if (!r.slave_port_select)
      begin
         n.in_buffer_full = 1'b0; // see RULE19
         n.out_buffer_full = 1'b0; // see RULE19
      end

      // pins
      n.dataOut = n.outLatch;                                      // see RULE16
      n.dataOe  = r.slave_port_select ? {PORT_W{readAct}} : ~r.dataDir;      // see RULE7 RULE15 RULE17
      n.ctrlOut = r.ctrlLatch;
      n.ctrlOe  = ~r.ctrlDir;                                      // see RULE1 RULE3
      n.irq     = r.irqFlags[BIT_SLAVE_IRQ] & r.irqEn[BIT_SLAVE_IRQ]; // see RULE20
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         r <= RESET_ST; // see RULE4
      end
      else
      begin
         r <= n;
      end
   end

   // ==========================================================
   // outputs
   assign prdata       = r.prdata;
   assign pready       = r.pready;
   assign pslverr      = r.pslverr;
   assign dataPinOut   = r.dataOut;
   assign dataPinOe    = r.dataOe;
   assign ctrlPinOut   = r.ctrlOut;
   assign ctrlPinOe    = r.ctrlOe;
   assign slavePortIrq = r.irq;

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   property p_ctrl_dir;
      ctrlPinOe == ~$past(r.ctrlDir);
   endproperty
   a_ctrl_dir: assert property (p_ctrl_dir) else $error("control pin enable wrong"); // see RULE1

   property p_analog_read;
      (apbAccess && !pwrite && regIdx == IDX_CTRL_PORT && !ctrlDigital) |=> prdata == 32'h0;
   endproperty
   a_analog_read: assert property (p_analog_read) else $error("analog pin read not zero"); // see RULE2

   property p_reset_analog;
      $past(reset) |-> !ctrlDigital && r.ctrlDir == RST_CTRL_DIR && !r.slave_port_select;
   endproperty
   a_reset_analog: assert property (p_reset_analog) else $error("reset defaults wrong"); // see RULE4

   property p_read_drive;
      readAct |=> dataPinOe == 8'hff;
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("host read not driven"); // see RULE15

   property p_psp_release;
      (r.slave_port_select && !readAct) |=> dataPinOe == 8'h00;
   endproperty
   a_psp_release: assert property (p_psp_release) else $error("data dir not ignored"); // see RULE7

   property p_capture;
      writeEnd |=> r.inLatch == $past(r.liveData);
   endproperty
   a_capture: assert property (p_capture) else $error("input latch not captured"); // see RULE10

   property p_write_done;
      (writeEnd && r.slave_port_select && r.wrStage == STG_IDLE)
         ##1 r.slave_port_select [*7] |-> ##[0:1] (r.in_buffer_full && r.irqFlags[BIT_SLAVE_IRQ]) || !r.slave_port_select;
   endproperty
   a_write_done: assert property (p_write_done) else $error("write completion late"); // see RULE11

   property p_ibf_clear;
      (dataRead && !(r.wrStage == STG_WAIT_Q4 && r.phase == PH_FOURTH)) |=> !r.in_buffer_full;
   endproperty
   a_ibf_clear: assert property (p_ibf_clear) else $error("input full not cleared"); // see RULE12

   property p_overrun;
      (writeEnd && r.in_buffer_full) |=> r.in_buffer_overrun;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // see RULE13

   property p_in_buffer_overrun_hold;
      (r.in_buffer_overrun && !(apbDone && pwrite && regIdx == IDX_CTRL_DIR)) |=> r.in_buffer_overrun;
   endproperty
   a_in_buffer_overrun_hold: assert property (p_in_buffer_overrun_hold) else $error("overrun lost"); // see RULE14

   property p_obf_low;
      (!r.out_buffer_full && !dataWrite) |=> !r.out_buffer_full;
   endproperty
   a_obf_low: assert property (p_obf_low) else $error("output full set by itself"); // see RULE18

   property p_not_psp;
      !r.slave_port_select |=> !r.in_buffer_full && !r.out_buffer_full;
   endproperty
   a_not_psp: assert property (p_not_psp) else $error("flags not held clear"); // see RULE19

   property p_irq_mask;
      slavePortIrq == ($past(r.irqFlags[BIT_SLAVE_IRQ]) && $past(r.irqEn[BIT_SLAVE_IRQ]));
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("irq masking wrong"); // see RULE20

   c_host_write: cover property (writeEnd ##[1:8] r.in_buffer_full);
   c_host_read:  cover property (readEnd ##[1:8] r.irqFlags[BIT_SLAVE_IRQ]);
   c_overrun:    cover property ($rose(r.in_buffer_overrun));
   c_bad_addr:   cover property (pready && pslverr);

endmodule

// >>> design/pspx_pkg.sv
package pspx_pkg;

   // ==========================================================
   // bus geometry
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int PORT_W = 8;
   localparam int CTRL_W = 3;

   // ==========================================================
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_DATA_PORT = 8'h08;
   localparam logic [7:0] IDX_CTRL_PORT = 8'h09;
   localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0c;
   localparam logic [7:0] IDX_DATA_DIR  = 8'h88;
   localparam logic [7:0] IDX_CTRL_DIR  = 8'h89;
   localparam logic [7:0] IDX_IRQ_EN    = 8'h8c;
   localparam logic [7:0] IDX_ANALOG    = 8'h9f;

   // ==========================================================
   // field positions
   localparam int BIT_IBF       = 7;
   localparam int BIT_OBF       = 6;
   localparam int BIT_IN_BUFFER_OVERRUN      = 5;
   localparam int BIT_PSP_MODE  = 4;
   localparam int BIT_SLAVE_IRQ = 7;
   localparam int PIN_READ      = 0;
   localparam int PIN_WRITE     = 1;
   localparam int PIN_CS        = 2;

   // ==========================================================
   // reset values
   localparam logic [2:0] RST_CTRL_DIR  = 3'h7;
   localparam logic       RST_PSP_MODE  = 1'h0;
   localparam logic [7:0] RST_DATA_DIR  = 8'hff;
   localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
   localparam logic [7:0] RST_IRQ_EN    = 8'h00;
   localparam logic [2:0] RST_ANALOG    = 3'h0;
   localparam logic [7:0] RST_LATCH     = 8'h00;

   // ==========================================================
   // analog select code that makes the control pins digital
   localparam logic [2:0] ANALOG_DIGITAL_CODE = 3'h6;

   // ==========================================================
   // four-phase instruction clock, one phase per clk_sys cycle
   localparam logic [1:0] PH_SECOND = 2'h1;
   localparam logic [1:0] PH_FOURTH = 2'h3;

   typedef enum logic [1:0] {STG_IDLE, STG_WAIT_Q2, STG_WAIT_Q4} pspx_stage_t;

   typedef struct packed {
      logic [1:0]  phase;
      logic [2:0]  ctrlSync1;
      logic [2:0]  ctrlSync2;
      logic [7:0]  dataSync1;
      logic [7:0]  dataSync2;
      logic        writeActPrev;
      logic        readActPrev;
      logic [7:0]  liveData;
      logic [7:0]  inLatch;
      logic [7:0]  outLatch;
      logic [2:0]  ctrlLatch;
      logic [7:0]  dataDir;
      logic [2:0]  ctrlDir;
      logic        slave_port_select;
      logic        in_buffer_full;
      logic        out_buffer_full;
      logic        in_buffer_overrun;
      logic        ibovArm;
      logic [7:0]  irqFlags;
      logic [7:0]  irqEn;
      logic [2:0]  anaCfg;
      pspx_stage_t wrStage;
      pspx_stage_t rdStage;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic [7:0]  dataOut;
      logic [7:0]  dataOe;
      logic [2:0]  ctrlOut;
      logic [2:0]  ctrlOe;
      logic        irq;
   } pspx_state_t;

endpackage

// >>> testbench/pspx_host_model.sv
`timescale 1ns/10ps
module pspx_host_model
(
   // clock
   input  wire logic       clk_sys,
   // data pins as seen on the wire
   input  wire logic [7:0] pinLevel,
   // host strobes and data
   output logic      [2:0] hostCtrl,
   output logic      [7:0] hostData,
   output logic            hostDrive
);
   // ==========================================================
   // idle: all strobes high, data released
   initial
   begin
      hostCtrl  = 3'h7;
      hostData  = 8'h00;
      hostDrive = 1'b0;
   end

   // ==========================================================
   // host write: data first, then select and write low
   task automatic wrStart(input logic [7:0] d);
      @(posedge clk_sys);
      hostData  <= d;
      hostDrive <= 1'b1;
      @(posedge clk_sys);
      hostCtrl <= 3'h1;
      repeat (5) @(posedge clk_sys);
   endtask

   // data held past the strobe rise, then released
   task automatic wrEnd;
      hostCtrl <= 3'h7;
      repeat (4) @(posedge clk_sys);
      hostDrive <= 1'b0;
      repeat (12) @(posedge clk_sys);
   endtask

   // ==========================================================
   // host read: select and read low, byte taken before the rise
   task automatic rdStart;
      @(posedge clk_sys);
      hostCtrl <= 3'h2;
      repeat (6) @(posedge clk_sys);
   endtask

   task automatic rdEnd(output logic [7:0] got);
      got = pinLevel;
      hostCtrl <= 3'h7;
      repeat (14) @(posedge clk_sys);
   endtask
endmodule

// >>> testbench/pspx_slave_port_bench.sv
`timescale 1ns/10ps
module pspx_slave_port_bench;
   import pspx_pkg::*;

   // ==========================================================
   // byte addresses
   localparam logic [9:0] A_DATA = {IDX_DATA_PORT, 2'h0};
   localparam logic [9:0] A_CPRT = {IDX_CTRL_PORT, 2'h0};
   localparam logic [9:0] A_FLAG = {IDX_IRQ_FLAGS, 2'h0};
   localparam logic [9:0] A_DDIR = {IDX_DATA_DIR, 2'h0};
   localparam logic [9:0] A_CDIR = {IDX_CTRL_DIR, 2'h0};
   localparam logic [9:0] A_EN   = {IDX_IRQ_EN, 2'h0};
   localparam logic [9:0] A_ANA  = {IDX_ANALOG, 2'h0};

   // ==========================================================
   // signals
   logic        clk_sys     = 1'b0;
   logic        reset       = 1'b1;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [9:0]  paddr       = 10'h000;
   logic [31:0] pwdata      = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  dataPinIn;
   logic [7:0]  dataPinOut;
   logic [7:0]  dataPinOe;
   logic [2:0]  ctrlPinIn;
   logic [2:0]  ctrlPinOut;
   logic [2:0]  ctrlPinOe;
   logic        slavePortIrq;
   logic [2:0]  hostCtrl;
   logic [7:0]  hostData;
   logic        hostDrive;
   logic [7:0]  hostGot;
   logic [7:0]  idlePat     = 8'h00;
   logic [31:0] rdData;
   logic        rdErr;
   int          miscompares = 0;
   int          checksDone  = 0;
   int          cycles      = 0;

   // ==========================================================
   // wire levels: released data pins float to a moving pattern
   assign dataPinIn = (dataPinOe & dataPinOut)
                    | (~dataPinOe & (hostDrive ? hostData : idlePat));
   assign ctrlPinIn = (ctrlPinOe & ctrlPinOut) | (~ctrlPinOe & hostCtrl);

   pspx_slave_port pspx_slave_port_inst
   (
      .clk_sys      (clk_sys),
      .reset        (reset),
      .psel         (psel),
      .penable      (penable),
      .pwrite       (pwrite),
      .paddr        (paddr),
      .pwdata       (pwdata),
      .prdata       (prdata),
      .pready       (pready),
      .pslverr      (pslverr),
      .dataPinIn    (dataPinIn),
      .dataPinOut   (dataPinOut),
      .dataPinOe    (dataPinOe),
      .ctrlPinIn    (ctrlPinIn),
      .ctrlPinOut   (ctrlPinOut),
      .ctrlPinOe    (ctrlPinOe),
      .slavePortIrq (slavePortIrq)
   );

   pspx_host_model pspx_host_model_inst
   (
      .clk_sys   (clk_sys),
      .pinLevel  (dataPinIn),
      .hostCtrl  (hostCtrl),
      .hostData  (hostData),
      .hostDrive (hostDrive)
   );

   // ==========================================================
   // clock, idle pattern, timeout
   initial
   begin
      forever #50 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
   begin
      idlePat <= idlePat + 8'h01;
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         finish_test;
      end
   end

   // ==========================================================
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
         miscompares++;
      end
   endtask

   task automatic apb(input logic [9:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1);
      chk({31'h0, pready}, 32'h1);
      rdData = prdata;
      rdErr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      apb(a, 1'b1, {24'h0, v});
   endtask

   task automatic rdChk(input logic [9:0] a, input logic [7:0] e);
      apb(a, 1'b0, 32'h0);
      chk(rdData, {24'h0, e});
   endtask

   task automatic irqChk(input logic e);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, slavePortIrq}, {31'h0, e});
   endtask

   task automatic finish_test;
      $display("checks %0d, mismatches %0d", checksDone, miscompares);
      if (miscompares == 0 && checksDone > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task automatic test_reset;
      rdChk(A_CDIR, 8'h07);
      rdChk(A_FLAG, 8'h00);
      rdChk(A_EN, 8'h00);
      rdChk(A_ANA, 8'h00);
      rdChk(A_CPRT, 8'h00);
      chk({29'h0, ctrlPinOe}, 32'h0);
      apb(10'h3fc, 1'b0, 32'h0);
      chk({31'h0, rdErr}, 32'h1);
      chk(rdData, 32'h0);
      $display("test reset done");
   endtask

   task automatic test_gpio;
      wr(A_CDIR, 8'h02);
      irqChk(1'b0);
      chk({29'h0, ctrlPinOe}, 32'h5);
      wr(A_CPRT, 8'h04);
      wr(A_ANA, ANALOG_DIGITAL_CODE);
      repeat (4) @(posedge clk_sys);
      chk({29'h0, ctrlPinOut}, 32'h4);
      rdChk(A_CPRT, 8'h06);
      wr(A_DDIR, 8'h0f);
      repeat (2) @(posedge clk_sys);
      chk({24'h0, dataPinOe}, 32'hf0);
      wr(A_CDIR, 8'h07);
      $display("test gpio done");
   endtask

   task automatic test_hostwr;
      wr(A_CDIR, 8'h17);
      rdChk(A_CDIR, 8'h17);
      wr(A_DDIR, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk({24'h0, dataPinOe}, 32'h0);
      wr(A_EN, 8'h80);
      pspx_host_model_inst.wrStart(8'ha5);
      rdChk(A_DATA, 8'ha5);
      pspx_host_model_inst.wrEnd();
      irqChk(1'b1);
      rdChk(A_FLAG, 8'h80);
      rdChk(A_CDIR, 8'h97);
      rdChk(A_DATA, 8'ha5);
      rdChk(A_CDIR, 8'h17);
      irqChk(1'b1);
      wr(A_EN, 8'h00);
      irqChk(1'b0);
      wr(A_EN, 8'h80);
      irqChk(1'b1);
      wr(A_FLAG, 8'h00);
      irqChk(1'b0);
      $display("test host write done");
   endtask

   task automatic test_overrun;
      pspx_host_model_inst.wrStart(8'h11);
      pspx_host_model_inst.wrEnd();
      pspx_host_model_inst.wrStart(8'h22);
      pspx_host_model_inst.wrEnd();
      rdChk(A_CDIR, 8'hb7);
      wr(A_CDIR, 8'h27);
      rdChk(A_CDIR, 8'h27);
      wr(A_CDIR, 8'h37);
      rdChk(A_CDIR, 8'h37);
      rdChk(A_DATA, 8'h22);
      wr(A_CDIR, 8'h17);
      rdChk(A_CDIR, 8'h17);
      wr(A_FLAG, 8'h00);
      $display("test overrun done");
   endtask

   task automatic test_hostrd;
      wr(A_DATA, 8'h3c);
      rdChk(A_CDIR, 8'h57);
      rdChk(A_DATA, 8'h22);
      pspx_host_model_inst.rdStart();
      chk({24'h0, dataPinOe}, 32'hff);
      chk({24'h0, dataPinIn}, 32'h3c);
      rdChk(A_CDIR, 8'h17);
      wr(A_DATA, 8'h5a);
      repeat (2) @(posedge clk_sys);
      rdChk(A_CDIR, 8'h17);
      pspx_host_model_inst.rdEnd(hostGot);
      chk({24'h0, hostGot}, 32'h5a);
      chk({24'h0, dataPinOe}, 32'h0);
      rdChk(A_FLAG, 8'h80);
      rdChk(A_CDIR, 8'h17);
      $display("test host read done");
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      test_reset;
      test_gpio;
      test_hostwr;
      test_overrun;
      test_hostrd;
      finish_test;
   end
endmodule
